// ---- design/ctm_compact_timer.sv ----
// Contract
// [RL1] sixteen-bit counter counts only upward on each selected clock tick
// [RL2] period comparator matches eight-bit value against counter upper byte only
// [RL3] compare A matches sixteen-bit value against the whole counter
// [RL4] no software write to counter; counter-on rising edge clears it
// [RL5] counter clears on overflow or selected comparator match, raising events
// [RL6] pause bit freezes counter; clearing it resumes from held value
// [RL7] three-bit select picks system, divided, time-base or external edge clock
// [RL8] counter-on high runs; rise clears count, fall stops and keeps count
// [RL9] in compare mode counter-on rise forces pin to initial level
// [RL10] low three bits of control zero read as zero
// [RL11] two-bit mode: compare output, undefined, pwm, timer/counter
// [RL12] software turns timer off before mode change; pin unused in timer mode
// [RL13] compare mode A match: none, low, high or toggle pin
// [RL14] pwm action: inactive, active, waveform, undefined; unused in timer mode
// [RL15] requested level equal to present level gives no visible pin change
// [RL16] software changes action field only while timer is off
// [RL17] initial-level bit: compare initial level, pwm active level, timer none
// [RL18] invert bit inverts pin output; no effect in timer mode
// [RL19] swap bit exchanges period and duty roles of both compare values
// [RL20] clear-select: one clears on A match, zero on period match or overflow; in pwm mode the code ignores it and clears on the period-role match
// [RL21] low byte goes through shared buffer, committed or latched at high byte
// [RL22] separate A and period match flags set on the matching count cycle
//
// The Wishbone interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
module ctm_compact_timer #(
	parameter int DATA_W = 32,
	parameter int ADR_W = 8
) (
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [ADR_W-1:0] wb_adr_i,
	input wire logic [DATA_W/8-1:0] wb_sel_i,
	input wire logic [DATA_W-1:0] wb_dat_i,
	output logic [DATA_W-1:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic externalCountPin,
	input wire logic timeBaseClock,
	output logic timerOutputPin,
	output logic timerOutputPinEn
);
	import ctm_pkg::*;

	if (DATA_W < CTM_BYTE_W || DATA_W % CTM_BYTE_W != 0 || ADR_W < 8) begin : g_badParam
		$error("ctm_compact_timer: bus widths not supported");
	end

	function automatic logic divHit(input logic [CTM_PRE_W-1:0] pre, input logic [CTM_PRE_W-1:0] mask);
		return (pre & mask) == mask;
	endfunction

	logic pause_q;
	ctm_cks_t cks_q;
	logic on_q;
	ctm_mode_t mode_q;
	logic [1:0] act_q;
	logic init_q;
	logic inv_q;
	logic swap_q;
	logic clrSel_q;
	logic [CTM_CNT_W-1:0] cmpA_q;
	logic [CTM_BYTE_W-1:0] period_q;
	logic [CTM_BYTE_W-1:0] buf_q;
	logic [CTM_BYTE_W-1:0] buf_d;
	logic [CTM_CNT_W-1:0] cnt_q;
	logic [CTM_CNT_W-1:0] cnt_d;
	logic aFlag_q;
	logic pFlag_q;
	logic pinLevel_q;
	logic pinLevel_d;
	logic ack_q;
	logic [DATA_W-1:0] datOut_q;
	logic [CTM_PRE_W-1:0] pre_q;
	logic extPrev_q;
	logic tbcPrev_q;
	logic pinOut_q;
	logic pinEn_q;

	// bus decode
	wire logic req = wb_cyc_i & wb_stb_i & ~ack_q;
	wire logic wr = req & wb_we_i & wb_sel_i[0];
	wire logic rd = req & ~wb_we_i;
	wire logic [CTM_BYTE_W-1:0] wrData = wb_dat_i[CTM_BYTE_W-1:0];
	wire logic hitCtrl0 = wb_adr_i == ADR_W'(CTM_ADR_CTRL0);
	wire logic hitCtrl1 = wb_adr_i == ADR_W'(CTM_ADR_CTRL1);
	wire logic hitCntLo = wb_adr_i == ADR_W'(CTM_ADR_CNT_LO);
	wire logic hitCntHi = wb_adr_i == ADR_W'(CTM_ADR_CNT_HI);
	wire logic hitCmpALo = wb_adr_i == ADR_W'(CTM_ADR_CMPA_LO);
	wire logic hitCmpAHi = wb_adr_i == ADR_W'(CTM_ADR_CMPA_HI);
	wire logic hitPeriod = wb_adr_i == ADR_W'(CTM_ADR_PERIOD);
	wire logic hitStatus = wb_adr_i == ADR_W'(CTM_ADR_STATUS);
	wire logic wrCtrl0 = wr & hitCtrl0;
	wire logic onRise = wrCtrl0 & wrData[CTM_C0_ON] & ~on_q; // RL4
	wire logic clrA = wr & hitStatus & wrData[CTM_ST_AFLAG];
	wire logic clrP = wr & hitStatus & wrData[CTM_ST_PFLAG];

	// readback; unimplemented control zero bits stay zero
	wire logic [CTM_BYTE_W-1:0] ctrl0Read = {pause_q, cks_q, on_q, 3'h0}; // RL10
	wire logic [CTM_BYTE_W-1:0] ctrl1Read = {mode_q, act_q, init_q, inv_q, swap_q, clrSel_q};
	wire logic [CTM_BYTE_W-1:0] statusRead = {6'h00, pFlag_q, aFlag_q};
	wire logic [CTM_BYTE_W-1:0] rdByte =
		hitCtrl0 ? ctrl0Read :
		hitCtrl1 ? ctrl1Read :
		(hitCntLo | hitCmpALo) ? buf_q : // RL21
		hitCntHi ? cnt_q[15:8] :
		hitCmpAHi ? cmpA_q[15:8] :
		hitPeriod ? period_q :
		hitStatus ? statusRead : CTM_BYTE_ZERO;

	// count clock selection
	wire logic extRise = externalCountPin & ~extPrev_q;
	wire logic extFall = ~externalCountPin & extPrev_q;
	wire logic tbcRise = timeBaseClock & ~tbcPrev_q;
	logic tick;
	always_comb begin
		case (cks_q) // RL7
			CTM_CK_SYS4: tick = divHit(pre_q, CTM_DIV4_MASK);
			CTM_CK_SYS: tick = 1'b1;
			CTM_CK_H16: tick = divHit(pre_q, CTM_DIV16_MASK);
			CTM_CK_H64: tick = divHit(pre_q, CTM_DIV64_MASK);
			CTM_CK_TBC: tick = tbcRise;
			CTM_CK_H8: tick = divHit(pre_q, CTM_DIV8_MASK);
			CTM_CK_EXTR: tick = extRise;
			CTM_CK_EXTF: tick = extFall;
			default: tick = 1'b0;
		endcase
	end

	// comparators look at the value the counter is about to take, so a
	// period value of n gives exactly n*256 counts and zero means overflow
	wire logic run = on_q & ~pause_q; // RL6 RL8
	wire logic step = run & tick; // RL1
	wire logic [CTM_CNT_W-1:0] cntInc = cnt_q + CTM_CNT_ONE;
	wire logic modePwm = mode_q == CTM_MODE_PWM;
	wire logic modeCmp = mode_q == CTM_MODE_CMP;
	wire logic aHit = step & (cntInc == cmpA_q) & (cmpA_q != CTM_CMPA_RST); // RL3
	wire logic pHit = step & (cntInc[15:8] == period_q) & (cntInc[7:0] == CTM_BYTE_ZERO); // RL2
	wire logic periodHit = swap_q ? aHit : pHit; // RL19
	wire logic clrNow = modePwm ? periodHit : (clrSel_q ? aHit : pHit); // RL20
	wire logic pFlagSet = pHit & ~(clrSel_q & ~modePwm); // RL22
	wire logic dutyActive = swap_q ? (cnt_q[15:8] < period_q) : (cnt_q < cmpA_q); // RL19

	always_comb begin
		cnt_d = cnt_q;
		if (onRise) begin
			cnt_d = CTM_CNT_RST; // RL4 RL8
		end else if (step) begin
			cnt_d = clrNow ? CTM_CNT_RST : cntInc; // RL5 RL1
		end
	end

	always_comb begin
		buf_d = buf_q;
		if (wr & hitCmpALo) begin
			buf_d = wrData; // RL21
		end else if (rd & hitCntHi) begin
			buf_d = cnt_q[7:0]; // RL21
		end else if (rd & hitCmpAHi) begin
			buf_d = cmpA_q[7:0]; // RL21
		end
	end

	always_comb begin
		pinLevel_d = pinLevel_q;
		if (modeCmp) begin
			if (onRise) begin
				pinLevel_d = init_q; // RL9 RL17
			end else if (aHit) begin
				case (act_q) // RL13 RL15
					CTM_ACT_LOW: pinLevel_d = 1'b0;
					CTM_ACT_HIGH: pinLevel_d = 1'b1;
					CTM_ACT_TOGGLE: pinLevel_d = ~pinLevel_q;
					default: pinLevel_d = pinLevel_q;
				endcase
			end
		end else if (modePwm) begin
			case (act_q) // RL14 RL17
				CTM_PWM_INACTIVE: pinLevel_d = ~init_q;
				CTM_PWM_ACTIVE: pinLevel_d = init_q;
				CTM_PWM_WAVE: pinLevel_d = run ? (dutyActive ? init_q : ~init_q) : pinLevel_q;
				default: pinLevel_d = ~init_q;
			endcase
		end
	end

	// timer mode releases the pin to other functions
	wire logic pinOut_d = (mode_q == CTM_MODE_TIMER) ? 1'b0 : pinLevel_q ^ inv_q; // RL18

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			pause_q <= CTM_CTRL0_RST[CTM_C0_PAUSE];
			cks_q <= ctm_cks_t'(CTM_CTRL0_RST[CTM_C0_CKS_LO+:3]);
			on_q <= CTM_CTRL0_RST[CTM_C0_ON];
		end else if (wrCtrl0) begin
			pause_q <= wrData[CTM_C0_PAUSE]; // RL6
			cks_q <= ctm_cks_t'(wrData[CTM_C0_CKS_LO+:3]); // RL7
			on_q <= wrData[CTM_C0_ON]; // RL8
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			mode_q <= ctm_mode_t'(CTM_CTRL1_RST[CTM_C1_MODE_LO+:2]);
			act_q <= CTM_CTRL1_RST[CTM_C1_ACT_LO+:2];
			init_q <= CTM_CTRL1_RST[CTM_C1_INIT];
			inv_q <= CTM_CTRL1_RST[CTM_C1_INV];
			swap_q <= CTM_CTRL1_RST[CTM_C1_SWAP];
			clrSel_q <= CTM_CTRL1_RST[CTM_C1_CLRSEL];
		end else if (wr & hitCtrl1) begin
			mode_q <= ctm_mode_t'(wrData[CTM_C1_MODE_LO+:2]); // RL11
			act_q <= wrData[CTM_C1_ACT_LO+:2];
			init_q <= wrData[CTM_C1_INIT];
			inv_q <= wrData[CTM_C1_INV];
			swap_q <= wrData[CTM_C1_SWAP];
			clrSel_q <= wrData[CTM_C1_CLRSEL];
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			cmpA_q <= CTM_CMPA_RST;
			period_q <= CTM_PERIOD_RST;
		end else begin
			if (wr & hitCmpAHi) begin
				cmpA_q <= {wrData, buf_q}; // RL21
			end
			if (wr & hitPeriod) begin
				period_q <= wrData;
			end
		end
	end

	// a flag set in the same cycle as its clear survives
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			aFlag_q <= 1'b0;
			pFlag_q <= 1'b0;
		end else begin
			aFlag_q <= aHit | (aFlag_q & ~clrA); // RL22
			pFlag_q <= pFlagSet | (pFlag_q & ~clrP); // RL22
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			cnt_q <= CTM_CNT_RST;
			buf_q <= CTM_BUF_RST;
			pre_q <= '0;
			extPrev_q <= 1'b0;
			tbcPrev_q <= 1'b0;
			pinLevel_q <= 1'b0;
			pinOut_q <= 1'b0;
			pinEn_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			buf_q <= buf_d;
			pre_q <= pre_q + 1'b1;
			extPrev_q <= externalCountPin;
			tbcPrev_q <= timeBaseClock;
			pinLevel_q <= pinLevel_d;
			pinOut_q <= pinOut_d;
			pinEn_q <= mode_q != CTM_MODE_TIMER; // RL12
		end
	end

	// one-wait-state slave: every access, mapped or not, is acked
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			ack_q <= 1'b0;
			datOut_q <= '0;
		end else begin
			ack_q <= req;
			if (rd) begin
				datOut_q <= {{(DATA_W-CTM_BYTE_W){1'b0}}, rdByte};
			end
		end
	end

	assign wb_ack_o = ack_q;
	assign wb_dat_o = datOut_q;
	assign timerOutputPin = pinOut_q;
	assign timerOutputPinEn = pinEn_q;

	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rstn);

	sequence s_loWrite;
		wr && hitCmpALo;
	endsequence
	sequence s_hiWrite;
		wr && hitCmpAHi;
	endsequence
	sequence s_onRiseCmp;
		onRise && modeCmp;
	endsequence

	property p_onClear;
		onRise |=> (cnt_q == CTM_CNT_RST) && on_q;
	endproperty
	a_onClear: assert property (p_onClear) else $error("counter not cleared on enable rise"); // RL4

	property p_pauseHold;
		(pause_q && !onRise) |=> (cnt_q == $past(cnt_q));
	endproperty
	a_pauseHold: assert property (p_pauseHold) else $error("counter moved while paused"); // RL6

	property p_offHold;
		(!on_q && !onRise) |=> $stable(cnt_q);
	endproperty
	a_offHold: assert property (p_offHold) else $error("counter moved while off"); // RL8

	property p_countUp;
		(step && !clrNow && !onRise) |=> (cnt_q == $past(cnt_q) + CTM_CNT_ONE);
	endproperty
	a_countUp: assert property (p_countUp) else $error("counter did not increment"); // RL1

	property p_clearOnA;
		(aHit && clrSel_q && modeCmp && !onRise) |=> (cnt_q == CTM_CNT_RST) && aFlag_q;
	endproperty
	a_clearOnA: assert property (p_clearOnA) else $error("A match did not clear counter"); // RL20

	property p_periodFlag;
		(pHit && !clrSel_q && !modePwm && !onRise) |=> pFlag_q && (cnt_q == CTM_CNT_RST);
	endproperty
	a_periodFlag: assert property (p_periodFlag) else $error("period match lost"); // RL22

	property p_noPFlagOnA;
		(clrSel_q && modeCmp && !pFlag_q && !wr) |=> !pFlag_q;
	endproperty
	a_noPFlagOnA: assert property (p_noPFlagOnA) else $error("period flag set under A clear"); // RL20

	property p_ctrl0Zero;
		(rd && hitCtrl0) |=> (wb_dat_o[2:0] == 3'h0) && wb_ack_o;
	endproperty
	a_ctrl0Zero: assert property (p_ctrl0Zero) else $error("unimplemented bits read nonzero"); // RL10

	property p_initLevel;
		s_onRiseCmp |=> (pinLevel_q == $past(init_q)) ##1 (pinOut_q == ($past(init_q, 2) ^ $past(inv_q)));
	endproperty
	a_initLevel: assert property (p_initLevel) else $error("pin not set to initial level"); // RL9

	property p_toggle;
		(aHit && modeCmp && !onRise && act_q == CTM_ACT_TOGGLE) |=> (pinLevel_q != $past(pinLevel_q));
	endproperty
	a_toggle: assert property (p_toggle) else $error("pin did not toggle on A match"); // RL13

	property p_highHold;
		(aHit && modeCmp && !onRise && act_q == CTM_ACT_HIGH && pinLevel_q) |=> pinLevel_q;
	endproperty
	a_highHold: assert property (p_highHold) else $error("pin changed though level equal"); // RL15

	property p_polarity;
		(mode_q != CTM_MODE_TIMER) |=> (pinOut_q == ($past(pinLevel_q) ^ $past(inv_q)));
	endproperty
	a_polarity: assert property (p_polarity) else $error("pin polarity wrong"); // RL18

	property p_hiCommit;
		s_hiWrite |=> (cmpA_q == {$past(wrData), $past(buf_q)});
	endproperty
	a_hiCommit: assert property (p_hiCommit) else $error("compare high write did not commit buffer"); // RL21

	property p_loBuffer;
		s_loWrite |=> (buf_q == $past(wrData)) && $stable(cmpA_q);
	endproperty
	a_loBuffer: assert property (p_loBuffer) else $error("compare low write not buffered"); // RL21

	property p_pwmActive;
		(modePwm && act_q == CTM_PWM_ACTIVE) |=> (pinLevel_q == $past(init_q));
	endproperty
	a_pwmActive: assert property (p_pwmActive) else $error("pwm forced active level wrong"); // RL14
endmodule
`default_nettype wire

// ---- design/ctm_pkg.sv ----
`default_nettype none
package ctm_pkg;
	localparam int CTM_CNT_W = 16;
	localparam int CTM_BYTE_W = 8;
	localparam int CTM_PRE_W = 6;
	// register byte addresses on the bus
	localparam logic [7:0] CTM_ADR_CTRL0 = 8'h00;
	localparam logic [7:0] CTM_ADR_CTRL1 = 8'h04;
	localparam logic [7:0] CTM_ADR_CNT_LO = 8'h08;
	localparam logic [7:0] CTM_ADR_CNT_HI = 8'h0c;
	localparam logic [7:0] CTM_ADR_CMPA_LO = 8'h10;
	localparam logic [7:0] CTM_ADR_CMPA_HI = 8'h14;
	localparam logic [7:0] CTM_ADR_PERIOD = 8'h18;
	localparam logic [7:0] CTM_ADR_STATUS = 8'h1c;
	// control zero fields
	localparam int CTM_C0_PAUSE = 7;
	localparam int CTM_C0_CKS_LO = 4;
	localparam int CTM_C0_ON = 3;
	// control one fields
	localparam int CTM_C1_MODE_LO = 6;
	localparam int CTM_C1_ACT_LO = 4;
	localparam int CTM_C1_INIT = 3;
	localparam int CTM_C1_INV = 2;
	localparam int CTM_C1_SWAP = 1;
	localparam int CTM_C1_CLRSEL = 0;
	// status fields, write one to clear
	localparam int CTM_ST_AFLAG = 0;
	localparam int CTM_ST_PFLAG = 1;
	// reset values
	localparam logic [7:0] CTM_CTRL0_RST = 8'h00;
	localparam logic [7:0] CTM_CTRL1_RST = 8'h00;
	localparam logic [15:0] CTM_CMPA_RST = 16'h0000;
	localparam logic [7:0] CTM_PERIOD_RST = 8'h00;
	localparam logic [15:0] CTM_CNT_RST = 16'h0000;
	localparam logic [7:0] CTM_BUF_RST = 8'h00;
	localparam logic [15:0] CTM_CNT_ONE = 16'h0001;
	localparam logic [7:0] CTM_BYTE_ZERO = 8'h00;
	// prescaler taps, the high clock is taken as the system clock
	localparam logic [5:0] CTM_DIV4_MASK = 6'h03;
	localparam logic [5:0] CTM_DIV8_MASK = 6'h07;
	localparam logic [5:0] CTM_DIV16_MASK = 6'h0f;
	localparam logic [5:0] CTM_DIV64_MASK = 6'h3f;
	typedef enum logic [2:0] {
		CTM_CK_SYS4 = 3'b000,
		CTM_CK_SYS = 3'b001,
		CTM_CK_H16 = 3'b010,
		CTM_CK_H64 = 3'b011,
		CTM_CK_TBC = 3'b100,
		CTM_CK_H8 = 3'b101,
		CTM_CK_EXTR = 3'b110,
		CTM_CK_EXTF = 3'b111
	} ctm_cks_t;
	typedef enum logic [1:0] {
		CTM_MODE_CMP = 2'b00,
		CTM_MODE_UNDEF = 2'b01,
		CTM_MODE_PWM = 2'b10,
		CTM_MODE_TIMER = 2'b11
	} ctm_mode_t;
	typedef enum logic [1:0] {
		CTM_ACT_NONE = 2'b00,
		CTM_ACT_LOW = 2'b01,
		CTM_ACT_HIGH = 2'b10,
		CTM_ACT_TOGGLE = 2'b11
	} ctm_act_t;
	localparam logic [1:0] CTM_PWM_INACTIVE = 2'b00;
	localparam logic [1:0] CTM_PWM_ACTIVE = 2'b01;
	localparam logic [1:0] CTM_PWM_WAVE = 2'b10;
endpackage
`default_nettype wire

// ---- tb/tb_ctm_compact_timer.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_ctm_compact_timer;
	import ctm_pkg::*;
	logic core_clk, rstn, cyc, stb, we, extPin, tbClk, pin, pinEn, ack;
	logic [7:0] adr;
	logic [3:0] sel;
	logic [31:0] wdat, rdat;
	logic [7:0] r;
	logic [15:0] v, w;
	logic [1:0] act;
	logic ini, inv, lvl;
	int fails, nCompared, cycles, k, j, highs;
	// rows: address, byte select, write data, expected read
	logic [31:0] regRows [8] = '{{CTM_ADR_CTRL0, 8'h01, 8'h07, 8'h00}, {CTM_ADR_CTRL1, 8'h01, 8'ha5, 8'ha5},
		{CTM_ADR_CTRL1, 8'h01, 8'h00, 8'h00}, {CTM_ADR_PERIOD, 8'h01, 8'h5a, 8'h5a},
		{CTM_ADR_PERIOD, 8'h0e, 8'h33, 8'h5a}, {CTM_ADR_PERIOD, 8'h01, 8'h00, 8'h00},
		{8'h20, 8'h01, 8'hff, 8'h00}, {CTM_ADR_CNT_HI, 8'h01, 8'hff, 8'h00}};
	// rows: clock select, divisor (internal) or expected ticks (pins)
	logic [15:0] ckRows [5] = '{16'h0101, 16'h0004, 16'h0508, 16'h0210, 16'h0340};
	logic [15:0] exRows [3] = '{16'h0403, 16'h0605, 16'h0705};

	initial begin
		core_clk = 1'b0;
		forever #25 core_clk = ~core_clk;
	end

	ctm_compact_timer ctm_compact_timer_inst (.core_clk(core_clk), .rstn(rstn), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.externalCountPin(extPin), .timeBaseClock(tbClk), .timerOutputPin(pin), .timerOutputPinEn(pinEn));

	task close_out;
		$display("compared %0d mismatches %0d", nCompared, fails);
		if (fails == 0 && nCompared > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 10000) begin
			fails++;
			close_out;
		end
	end

	task chk(input logic [15:0] got, input logic [15:0] exp);
		nCompared++;
		if (got !== exp) begin
			fails++;
			$display("wrong value t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	task chkr(input logic [15:0] got, input int lo, input int hi);
		nCompared++;
		if ((got >= lo && got <= hi) !== 1'b1) begin
			fails++;
			$display("wrong value t=%0t got %h exp %h", $time, got, lo);
		end
	endtask

	// request held until ack is seen; data taken at that same edge; only the bench timeout ends a hung wait
	task wbx(input logic wr, input logic [7:0] a, input logic [7:0] d, input logic [3:0] s, output logic [7:0] q);
		@(posedge core_clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= wr;
		adr <= a;
		sel <= s;
		wdat <= {24'h000000, d};
		do begin
			@(posedge core_clk);
		end while (ack !== 1'b1);
		q = rdat[7:0];
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask

	task wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] q;
		wbx(1'b1, a, d, 4'h1, q);
	endtask

	task rd(input logic [7:0] a, output logic [7:0] q);
		wbx(1'b0, a, 8'h00, 4'h1, q);
	endtask

	// high byte first, so the low byte comes from the same instant
	task rdCnt(output logic [15:0] c);
		logic [7:0] h, l;
		rd(CTM_ADR_CNT_HI, h);
		rd(CTM_ADR_CNT_LO, l);
		c = {h, l};
	endtask

	initial begin
		rstn = 1'b0;
		{cyc, stb, we, extPin, tbClk} = 5'b00000;
		adr = 8'h00;
		sel = 4'h0;
		wdat = 32'h00000000;
		repeat (6) @(posedge core_clk);
		chk(ack, 1'b0);
		chk(pin, 1'b0);
		repeat (6) @(posedge core_clk);
		rstn <= 1'b1;
		repeat (2) @(posedge core_clk);
		chk(pinEn, 1'b1);
		rd(CTM_ADR_CTRL0, r);
		chk(r, CTM_CTRL0_RST);
		rd(CTM_ADR_CTRL1, r);
		chk(r, CTM_CTRL1_RST);
		$display("test reset done");
		for (k = 0; k < 8; k++) begin
			wbx(1'b1, regRows[k][31:24], regRows[k][15:8], regRows[k][19:16], r);
			rd(regRows[k][31:24], r);
			chk(r, regRows[k][7:0]);
		end
		$display("test registers done");
		for (k = 0; k < 5; k++) begin
			wr(CTM_ADR_CTRL0, {1'b0, ckRows[k][10:8], 4'h8});
			repeat (125) @(posedge core_clk);
			wr(CTM_ADR_CTRL0, {1'b0, ckRows[k][10:8], 4'h0});
			rdCnt(v);
			chkr(v, 128 / ckRows[k][7:0] - 1, 128 / ckRows[k][7:0] + 1);
		end
		for (k = 0; k < 3; k++) begin
			wr(CTM_ADR_CTRL0, {1'b0, exRows[k][10:8], 4'h8});
			// pulses stay wide so the sampled edge detect sees each one
			for (j = 0; j < 5; j++) begin
				@(posedge core_clk);
				extPin <= 1'b1;
				tbClk <= (j < 3);
				repeat (4) @(posedge core_clk);
				extPin <= 1'b0;
				tbClk <= 1'b0;
				repeat (3) @(posedge core_clk);
			end
			wr(CTM_ADR_CTRL0, {1'b0, exRows[k][10:8], 4'h0});
			rdCnt(v);
			chk(v, exRows[k][7:0]);
		end
		$display("test clock select done");
		wr(CTM_ADR_CTRL0, 8'h18);
		repeat (20) @(posedge core_clk);
		wr(CTM_ADR_CTRL0, 8'h98);
		rdCnt(v);
		repeat (30) @(posedge core_clk);
		rdCnt(w);
		chk(w, v);
		wr(CTM_ADR_CTRL0, 8'h18);
		repeat (10) @(posedge core_clk);
		rdCnt(w);
		chkr(w, v + 10, v + 16);
		wr(CTM_ADR_CTRL0, 8'h10);
		rdCnt(v);
		repeat (20) @(posedge core_clk);
		rdCnt(w);
		chk(w, v);
		wr(CTM_ADR_CTRL0, 8'h18);
		rdCnt(w);
		chkr(w, 0, 8);
		$display("test pause and on done");
		wr(CTM_ADR_CMPA_LO, 8'h10);
		wr(CTM_ADR_CMPA_HI, 8'h00);
		rd(CTM_ADR_CMPA_HI, r);
		chk(r, 8'h00);
		rd(CTM_ADR_CMPA_LO, r);
		chk(r, 8'h10);
		for (k = 0; k < 8; k++) begin
			act = k[1:0];
			ini = k[2];
			inv = k[2] ^ k[0];
			wr(CTM_ADR_CTRL0, 8'h10);
			wr(CTM_ADR_STATUS, 8'h03);
			wr(CTM_ADR_CTRL1, {2'b00, act, ini, inv, 2'b01});
			wr(CTM_ADR_CTRL0, 8'h18);
			repeat (3) @(posedge core_clk);
			chk(pin, ini ^ inv);
			repeat (20) @(posedge core_clk);
			lvl = (act == CTM_ACT_NONE) ? ini : (act == CTM_ACT_LOW) ? 1'b0 : (act == CTM_ACT_HIGH) ? 1'b1 : !ini;
			chk(pin, lvl ^ inv);
			rd(CTM_ADR_STATUS, r);
			chk(r, 8'h01);
			rdCnt(v);
			chkr(v, 0, 15);
		end
		$display("test compare output done");
		wr(CTM_ADR_CTRL0, 8'h10);
		wr(CTM_ADR_CMPA_LO, 8'h00);
		wr(CTM_ADR_CMPA_HI, 8'h00);
		wr(CTM_ADR_STATUS, 8'h03);
		wr(CTM_ADR_PERIOD, 8'h01);
		wr(CTM_ADR_CTRL1, 8'hc0);
		wr(CTM_ADR_CTRL0, 8'h18);
		repeat (300) @(posedge core_clk);
		rd(CTM_ADR_STATUS, r);
		chk(r, 8'h02);
		rdCnt(v);
		chkr(v, 30, 70);
		chk(pinEn, 1'b0);
		chk(pin, 1'b0);
		$display("test period done");
		wr(CTM_ADR_CTRL0, 8'h10);
		wr(CTM_ADR_CMPA_LO, 8'h80);
		wr(CTM_ADR_CMPA_HI, 8'h00);
		// last pass swaps roles: compare A (0x80) sets the period, the period byte the duty
		for (k = 0; k < 4; k++) begin
			wr(CTM_ADR_CTRL0, 8'h10);
			wr(CTM_ADR_CTRL1, {2'b10, (k == 3) ? 2'b10 : k[1:0], 2'b10, k == 3, 1'b0});
			wr(CTM_ADR_CTRL0, 8'h18);
			repeat (3) @(posedge core_clk);
			highs = 0;
			repeat (256) begin
				@(posedge core_clk);
				highs += (pin === 1'b1);
			end
			if (k == 2) begin
				chkr(highs[15:0], 124, 132);
			end else begin
				chk(highs[15:0], (k == 0) ? 16'h0000 : 16'h0100);
			end
		end
		$display("test pwm done");
		close_out;
	end
endmodule
`default_nettype wire
